/* rtl/rtc_alarm_top.sv */
`timescale 1ns/1ps
// Contract
// - First alarm seconds..day/date at 07h-0Ah.
// - Second alarm minutes..day/date at 0Bh-0Dh.
// - Bit 7 masks field out of compare.
// - Unmasked fields must all equal time.
// - Bit 6 picks weekday or date compare.
// - Compare exactly once per second tick.
// - Match sets alarm flag regardless of enables.
// - Interrupt needs flag, enable and select.
// - On backup, interrupt only if enabled.
// - Interrupt holds until host clears flag.
// - First alarm all masked: every second.
// - First alarm: seconds match only.
// - First alarm: minutes and seconds match.
// - First alarm: hours, minutes, seconds match.
// - First alarm: date plus time match.
// - First alarm: weekday plus time match.
// - Second alarm all masked: each minute.
// - Second alarm: minutes match at second zero.
// - Second alarm: hours and minutes match.
// - Second alarm: date, hours, minutes match.
// - Second alarm: weekday, hours, minutes match.
// - Values held as BCD, zero bits read zero.
// - Hours bit 6 mode, bit 5 PM/20h.
// - Flags cleared only by writing zero.
module rtc_alarm_top (
  input  wire logic core_clk,
  input  wire logic rst,
  input  wire logic scl_in,
  input  wire logic sda_in,
  output logic      sda_out,
  output logic      sda_oe,
  input  wire logic tick_1hz,
  input  wire logic on_backup,
  output logic      wave_or_irq_out,
  output logic      wave_or_irq_oe
);
  import rtc_alarm_pkg::*;

  typedef enum logic [2:0] {
    BUS_IDLE,
    BUS_ADDR,
    BUS_ACK_ADDR,
    BUS_WRITE,
    BUS_ACK_WRITE,
    BUS_READ,
    BUS_ACK_READ
  } bus_state_e;

  typedef struct packed {
    logic [REG_COUNT-1:0][7:0] regs;
    logic [4:0]                ptr;
    bus_state_e                bus_state;
    logic [3:0]                bit_cnt;
    logic [7:0]                shifter;
    logic                      first_byte;
    logic                      is_read;
    logic                      scl_prev;
    logic                      sda_prev;
    logic                      tick_prev;
    logic                      sda_oe;
    logic                      sda_out;
    logic                      irq_oe;
    logic                      irq_out;
  } top_s;

  top_s       st;
  top_s       next_st;
  logic [3:0] synced;
  logic       scl_s;
  logic       sda_s;
  logic       tick_s;
  logic       bk_s;
  logic       scl_rise;
  logic       scl_fall;
  logic       bus_start;
  logic       bus_stop;
  logic       tick_edge;
  logic       wr_en;
  logic [7:0] rd_byte;
  logic [7:0] ctrl;
  logic [7:0] flags_now;
  logic       irq_cond;

  alarm_cmp_if first_cmp ();
  alarm_cmp_if second_cmp ();

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [7:0] read_reg(input logic [REG_COUNT-1:0][7:0] regs, input logic [4:0] p);
    read_reg = (p <= LAST_REG) ? regs[p] : 8'h00;
  endfunction

  function automatic logic [4:0] step_ptr(input logic [4:0] p);
    step_ptr = (p >= LAST_REG) ? 5'h00 : 5'(p + 5'h01);
  endfunction

  // ****************************************
  // Pin synchronisers
  // ****************************************
  pin_sync #(.W(4)) u_sync (
    .core_clk (core_clk),
    .rst      (rst),
    .async_in ({on_backup, tick_1hz, sda_in, scl_in}),
    .sync_out (synced)
  );

  assign scl_s  = synced[0];
  assign sda_s  = synced[1];
  assign tick_s = synced[2];
  assign bk_s   = synced[3];

  // ****************************************
  // Alarm comparators
  // ****************************************
  assign first_cmp.al_sec  = st.regs[FIRST_ALARM_SECONDS];
  assign first_cmp.al_min  = st.regs[FIRST_ALARM_MINUTES];
  assign first_cmp.al_hr   = st.regs[FIRST_ALARM_HOURS];
  assign first_cmp.al_dd   = st.regs[FIRST_ALARM_DAY_DATE];
  assign first_cmp.t_sec   = st.regs[TIME_SECONDS];
  assign first_cmp.t_min   = st.regs[TIME_MINUTES];
  assign first_cmp.t_hr    = st.regs[TIME_HOURS];
  assign first_cmp.t_day   = st.regs[DAY_OF_WEEK];
  assign first_cmp.t_date  = st.regs[DATE_OF_MONTH];

  // Second alarm has no seconds field: fixed at second zero, unmasked
  assign second_cmp.al_sec = SECOND_ZERO;
  assign second_cmp.al_min = st.regs[SECOND_ALARM_MINUTES];
  assign second_cmp.al_hr  = st.regs[SECOND_ALARM_HOURS];
  assign second_cmp.al_dd  = st.regs[SECOND_ALARM_DAY_DATE];
  assign second_cmp.t_sec  = st.regs[TIME_SECONDS];
  assign second_cmp.t_min  = st.regs[TIME_MINUTES];
  assign second_cmp.t_hr   = st.regs[TIME_HOURS];
  assign second_cmp.t_day  = st.regs[DAY_OF_WEEK];
  assign second_cmp.t_date = st.regs[DATE_OF_MONTH];

  alarm_match u_first_match (
    .cmp (first_cmp)
  );

  alarm_match u_second_match (
    .cmp (second_cmp)
  );

  // ****************************************
  // Bus events
  // ****************************************
  assign scl_rise  = scl_s & ~st.scl_prev;
  assign scl_fall  = ~scl_s & st.scl_prev;
  assign bus_start = scl_s & st.scl_prev & st.sda_prev & ~sda_s;
  assign bus_stop  = scl_s & st.scl_prev & ~st.sda_prev & sda_s;
  assign tick_edge = tick_s & ~st.tick_prev;
  assign rd_byte   = read_reg(st.regs, st.ptr);
  assign ctrl      = st.regs[OUTPUT_AND_OSC_CTRL];
  assign flags_now = st.regs[FLAGS];

  assign irq_cond = ctrl[IRQ_NOT_WAVE_SELECT_BIT] & (~bk_s | ctrl[BACKUP_OUTPUT_ENABLE_BIT]) &
                    ((flags_now[FIRST_ALARM_FLAG_BIT] & ctrl[FIRST_IRQ_ENABLE_BIT]) |
                     (flags_now[SECOND_ALARM_FLAG_BIT] & ctrl[SECOND_IRQ_ENABLE_BIT]));

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    next_st           = st;
    next_st.scl_prev  = scl_s;
    next_st.sda_prev  = sda_s;
    next_st.tick_prev = tick_s;
    next_st.sda_out   = 1'b0;
    next_st.irq_out   = 1'b0;
    wr_en             = 1'b0;

    case (st.bus_state)
      BUS_ADDR: begin
        if (scl_rise) begin
          next_st.shifter = {st.shifter[6:0], sda_s};
          next_st.bit_cnt = 4'(st.bit_cnt + 4'h1);
        end else if (scl_fall && st.bit_cnt == 4'(BITS_PER_BYTE)) begin
          next_st.bit_cnt = 4'h0;
          if (st.shifter[7:1] == DEVICE_ADDR) begin
            next_st.is_read   = st.shifter[0];
            next_st.sda_oe    = 1'b1;
            next_st.bus_state = BUS_ACK_ADDR;
          end else begin
            next_st.bus_state = BUS_IDLE;
          end
        end
      end
      BUS_ACK_ADDR: begin
        if (scl_fall) begin
          if (st.is_read) begin
            next_st.shifter   = rd_byte;
            next_st.sda_oe    = ~rd_byte[7];
            next_st.bit_cnt   = 4'h1;
            next_st.bus_state = BUS_READ;
          end else begin
            next_st.sda_oe     = 1'b0;
            next_st.first_byte = 1'b1;
            next_st.bit_cnt    = 4'h0;
            next_st.bus_state  = BUS_WRITE;
          end
        end
      end
      BUS_WRITE: begin
        if (scl_rise) begin
          next_st.shifter = {st.shifter[6:0], sda_s};
          next_st.bit_cnt = 4'(st.bit_cnt + 4'h1);
        end else if (scl_fall && st.bit_cnt == 4'(BITS_PER_BYTE)) begin
          wr_en             = 1'b1;
          next_st.bit_cnt   = 4'h0;
          next_st.sda_oe    = 1'b1;
          next_st.bus_state = BUS_ACK_WRITE;
        end
      end
      BUS_ACK_WRITE: begin
        if (scl_fall) begin
          next_st.sda_oe    = 1'b0;
          next_st.bus_state = BUS_WRITE;
        end
      end
      BUS_READ: begin
        if (scl_fall) begin
          if (st.bit_cnt == 4'(BITS_PER_BYTE)) begin
            next_st.sda_oe    = 1'b0;
            next_st.ptr       = step_ptr(st.ptr);
            next_st.bus_state = BUS_ACK_READ;
          end else begin
            next_st.shifter = {st.shifter[6:0], 1'b0};
            next_st.sda_oe  = ~st.shifter[6];
            next_st.bit_cnt = 4'(st.bit_cnt + 4'h1);
          end
        end
      end
      BUS_ACK_READ: begin
        if (scl_rise && sda_s) begin
          next_st.bus_state = BUS_IDLE;
        end else if (scl_fall) begin
          next_st.shifter   = rd_byte;
          next_st.sda_oe    = ~rd_byte[7];
          next_st.bit_cnt   = 4'h1;
          next_st.bus_state = BUS_READ;
        end
      end
      default: begin
        next_st.sda_oe = 1'b0;
      end
    endcase

    // Pointer byte first, then data bytes with auto-increment
    if (wr_en) begin
      if (st.first_byte) begin
        next_st.ptr        = st.shifter[4:0];
        next_st.first_byte = 1'b0;
      end else begin
        if (st.ptr == FLAGS) begin
          next_st.regs[FLAGS] = flags_now & st.shifter & WRITE_MASK[FLAGS];
        end else if (st.ptr <= LAST_REG) begin
          next_st.regs[st.ptr] = st.shifter & WRITE_MASK[st.ptr];
        end
        if (st.ptr == OUTPUT_AND_OSC_CTRL && st.shifter[OSC_DISABLE_BIT] && !ctrl[OSC_DISABLE_BIT]) begin
          next_st.regs[FLAGS][OSC_STOPPED_FLAG_BIT] = 1'b1;
        end
        next_st.ptr = step_ptr(st.ptr);
      end
    end

    // Alarm events applied after host write so a set beats a clear
    if (tick_edge) begin
      if (first_cmp.hit) begin
        next_st.regs[FLAGS][FIRST_ALARM_FLAG_BIT] = 1'b1;
      end
      if (second_cmp.hit) begin
        next_st.regs[FLAGS][SECOND_ALARM_FLAG_BIT] = 1'b1;
      end
    end

    // Frame control and backup lockout override the bus sequencer
    if (bk_s || bus_stop) begin
      next_st.bus_state = BUS_IDLE;
      next_st.sda_oe    = 1'b0;
    end else if (bus_start) begin
      next_st.bus_state = BUS_ADDR;
      next_st.bit_cnt   = 4'h0;
      next_st.sda_oe    = 1'b0;
    end

    next_st.irq_oe = irq_cond;
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      st           <= '0;
      st.regs      <= REG_RESET;
      st.bus_state <= BUS_IDLE;
      st.scl_prev  <= 1'b1;
      st.sda_prev  <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign sda_out         = st.sda_out;
  assign sda_oe          = st.sda_oe;
  assign wave_or_irq_out = st.irq_out;
  assign wave_or_irq_oe  = st.irq_oe;

  // ****************************************
  // Checks
  // ****************************************
  first_flag_set_a: assert property (@(posedge core_clk) disable iff (rst)
    tick_edge && first_cmp.hit |=> flags_now[FIRST_ALARM_FLAG_BIT])
    else $error("first alarm match did not set its flag");

  flag_source_a: assert property (@(posedge core_clk) disable iff (rst)
    $rose(flags_now[SECOND_ALARM_FLAG_BIT]) |-> $past(tick_edge && second_cmp.hit))
    else $error("second alarm flag rose without a tick match");

  tick_once_a: assert property (@(posedge core_clk) disable iff (rst)
    $rose(flags_now[FIRST_ALARM_FLAG_BIT]) |-> $past(tick_edge))
    else $error("first alarm flag rose outside a second tick");

  every_second_a: assert property (@(posedge core_clk) disable iff (rst)
    tick_edge && first_cmp.al_sec[7] && first_cmp.al_min[7] && first_cmp.al_hr[7] && first_cmp.al_dd[7]
    |=> flags_now[FIRST_ALARM_FLAG_BIT])
    else $error("fully masked first alarm missed a second");

  second_zero_a: assert property (@(posedge core_clk) disable iff (rst)
    tick_edge && !flags_now[SECOND_ALARM_FLAG_BIT] && st.regs[TIME_SECONDS] != SECOND_ZERO
    |=> !flags_now[SECOND_ALARM_FLAG_BIT])
    else $error("second alarm fired away from second zero");

  irq_drive_a: assert property (@(posedge core_clk) disable iff (rst)
    flags_now[FIRST_ALARM_FLAG_BIT] && ctrl[FIRST_IRQ_ENABLE_BIT] && ctrl[IRQ_NOT_WAVE_SELECT_BIT] && !bk_s
    ##1 flags_now[FIRST_ALARM_FLAG_BIT] |-> wave_or_irq_oe && !wave_or_irq_out)
    else $error("enabled alarm flag did not pull the interrupt pin");

  backup_quiet_a: assert property (@(posedge core_clk) disable iff (rst)
    bk_s && !ctrl[BACKUP_OUTPUT_ENABLE_BIT] |=> !wave_or_irq_oe)
    else $error("interrupt driven on backup while disabled");

  irq_release_a: assert property (@(posedge core_clk) disable iff (rst)
    $fell(wave_or_irq_oe) |-> $past(!irq_cond))
    else $error("interrupt released while its cause still stood");

  alarm_write_a: assert property (@(posedge core_clk) disable iff (rst)
    wr_en && !st.first_byte && st.ptr == FIRST_ALARM_HOURS |=> st.regs[FIRST_ALARM_HOURS] == $past(st.shifter))
    else $error("first alarm hours write lost");

  weekday_zero_a: assert property (@(posedge core_clk) disable iff (rst)
    st.regs[DAY_OF_WEEK][7:3] == 5'h00 && st.regs[OUTPUT_AND_OSC_CTRL][6] == 1'b0)
    else $error("reserved register bits not zero");

endmodule

/* include/rtc_alarm_pkg.sv */
package rtc_alarm_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam int         REG_COUNT             = 17;
  localparam int         BITS_PER_BYTE         = 8;
  localparam logic [4:0] TIME_SECONDS          = 5'h00;
  localparam logic [4:0] TIME_MINUTES          = 5'h01;
  localparam logic [4:0] TIME_HOURS            = 5'h02;
  localparam logic [4:0] DAY_OF_WEEK           = 5'h03;
  localparam logic [4:0] DATE_OF_MONTH         = 5'h04;
  localparam logic [4:0] MONTH_CENTURY         = 5'h05;
  localparam logic [4:0] YEAR                  = 5'h06;
  localparam logic [4:0] FIRST_ALARM_SECONDS   = 5'h07;
  localparam logic [4:0] FIRST_ALARM_MINUTES   = 5'h08;
  localparam logic [4:0] FIRST_ALARM_HOURS     = 5'h09;
  localparam logic [4:0] FIRST_ALARM_DAY_DATE  = 5'h0A;
  localparam logic [4:0] SECOND_ALARM_MINUTES  = 5'h0B;
  localparam logic [4:0] SECOND_ALARM_HOURS    = 5'h0C;
  localparam logic [4:0] SECOND_ALARM_DAY_DATE = 5'h0D;
  localparam logic [4:0] OUTPUT_AND_OSC_CTRL   = 5'h0E;
  localparam logic [4:0] FLAGS                 = 5'h0F;
  localparam logic [4:0] BACKUP_CHARGE_SETUP   = 5'h10;
  localparam logic [4:0] LAST_REG              = 5'h10;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int FIELD_MASK_BIT           = 7;
  localparam int WEEKDAY_NOT_DATE_BIT     = 6;
  localparam int OSC_DISABLE_BIT          = 7;
  localparam int BACKUP_OUTPUT_ENABLE_BIT = 5;
  localparam int IRQ_NOT_WAVE_SELECT_BIT  = 2;
  localparam int SECOND_IRQ_ENABLE_BIT    = 1;
  localparam int FIRST_IRQ_ENABLE_BIT     = 0;
  localparam int OSC_STOPPED_FLAG_BIT     = 7;
  localparam int SECOND_ALARM_FLAG_BIT    = 1;
  localparam int FIRST_ALARM_FLAG_BIT     = 0;

  localparam logic [7:0] TIME_VALUE_BITS = 8'h7F;
  localparam logic [7:0] DAY_DATE_BITS   = 8'h3F;
  localparam logic [7:0] SECOND_ZERO     = 8'h00;

  // ****************************************
  // Reset values and writable bits, index 10h leftmost
  // ****************************************
  localparam logic [REG_COUNT-1:0][7:0] REG_RESET = '{
    8'h00, 8'h80, 8'h18, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h01, 8'h01, 8'h01, 8'h00, 8'h00, 8'h00};
  localparam logic [REG_COUNT-1:0][7:0] WRITE_MASK = '{
    8'hFF, 8'h83, 8'hBF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF,
    8'hFF, 8'hFF, 8'h9F, 8'h3F, 8'h07, 8'h7F, 8'h7F, 8'h7F};

  // ****************************************
  // Serial port
  // ****************************************
  localparam logic [6:0] DEVICE_ADDR = 7'h68;

endpackage

/* include/alarm_cmp_if.sv */
`timescale 1ns/1ps
interface alarm_cmp_if;
  logic [7:0] al_sec;
  logic [7:0] al_min;
  logic [7:0] al_hr;
  logic [7:0] al_dd;
  logic [7:0] t_sec;
  logic [7:0] t_min;
  logic [7:0] t_hr;
  logic [7:0] t_day;
  logic [7:0] t_date;
  logic       hit;

  modport src (output al_sec, al_min, al_hr, al_dd, t_sec, t_min, t_hr, t_day, t_date, input hit);
  modport cmp (input al_sec, al_min, al_hr, al_dd, t_sec, t_min, t_hr, t_day, t_date, output hit);
endinterface

/* rtl/pin_sync.sv */
`timescale 1ns/1ps
module pin_sync #(
  parameter int W = 1
) (
  input  wire logic         core_clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);
  typedef struct packed {
    logic [W-1:0] first;
    logic [W-1:0] second;
  } sync_s;

  sync_s st;
  sync_s next_st;

  always_comb begin
    next_st        = st;
    next_st.first  = async_in;
    next_st.second = st.first;
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign sync_out = st.second;
endmodule

/* rtl/alarm_match.sv */
`timescale 1ns/1ps
module alarm_match (
  alarm_cmp_if.cmp cmp
);
  import rtc_alarm_pkg::*;

  logic       sec_ok;
  logic       min_ok;
  logic       hr_ok;
  logic       dd_ok;
  logic [7:0] dd_target;

  // ****************************************
  // Masked field compare
  // ****************************************
  always_comb begin
    sec_ok    = cmp.al_sec[FIELD_MASK_BIT] |
                ((cmp.al_sec & TIME_VALUE_BITS) == (cmp.t_sec & TIME_VALUE_BITS));
    min_ok    = cmp.al_min[FIELD_MASK_BIT] |
                ((cmp.al_min & TIME_VALUE_BITS) == (cmp.t_min & TIME_VALUE_BITS));
    hr_ok     = cmp.al_hr[FIELD_MASK_BIT] |
                ((cmp.al_hr & TIME_VALUE_BITS) == (cmp.t_hr & TIME_VALUE_BITS));
    dd_target = cmp.al_dd[WEEKDAY_NOT_DATE_BIT] ? cmp.t_day : cmp.t_date;
    dd_ok     = cmp.al_dd[FIELD_MASK_BIT] |
                ((cmp.al_dd & DAY_DATE_BITS) == (dd_target & DAY_DATE_BITS));
  end

  assign cmp.hit = sec_ok & min_ok & hr_ok & dd_ok;
endmodule

/* verif/i2c_host_model.sv */
`timescale 1ns/1ps
module i2c_host_model (
  input  wire logic core_clk,
  input  wire logic sda_line,
  output logic      scl,
  output logic      sda_low
);

  // ****************************************
  // Serial bus master
  // ****************************************
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end

  task automatic wait_clk(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  // Data set up while clock low, sampled at end of high phase
  task automatic put_bit(input logic b, output logic seen);
    sda_low <= ~b;
    wait_clk(4);
    scl <= 1'b1;
    wait_clk(8);
    seen = sda_line;
    scl <= 1'b0;
    wait_clk(4);
  endtask

  task automatic start_cond();
    sda_low <= 1'b0;
    wait_clk(4);
    scl <= 1'b1;
    wait_clk(8);
    sda_low <= 1'b1;
    wait_clk(8);
    scl <= 1'b0;
    wait_clk(4);
  endtask

  task automatic stop_cond();
    sda_low <= 1'b1;
    wait_clk(4);
    scl <= 1'b1;
    wait_clk(8);
    sda_low <= 1'b0;
    wait_clk(8);
  endtask

  task automatic send_byte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) put_bit(d[i], s);
    put_bit(1'b1, s);
    ack = ~s;
  endtask

  // Last byte of a read is answered with a release (no acknowledge)
  task automatic recv_byte(input logic last, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      put_bit(1'b1, s);
      d[i] = s;
    end
    put_bit(last, s);
  endtask

endmodule

/* verif/rtc_time_of_day_alarms_tb.sv */
`timescale 1ns/1ps
module rtc_time_of_day_alarms_tb;
  import rtc_alarm_pkg::*;

  logic       core_clk;
  logic       rst;
  logic       tick_1hz;
  logic       on_backup;
  logic       scl;
  logic       sda_low;
  logic       sda_out;
  logic       sda_oe;
  logic       wave_or_irq_out;
  logic       wave_or_irq_oe;
  wire        sda_line = ~sda_low & (~sda_oe | sda_out);
  wire        irq_line = ~wave_or_irq_oe | wave_or_irq_out;
  int         n_fail;
  int         checks;
  // Time seconds, first alarm sec/min/hr/daydate, second alarm min/hr/daydate, flags
  logic [71:0] mask_rows [11] = '{
    72'h30_808080C0_808080_01,
    72'h00_80808080_808080_03,
    72'h00_00808080_458080_03,
    72'h00_01808080_468080_00,
    72'h00_00458080_451280_03,
    72'h00_00448080_451380_00,
    72'h00_00451280_451215_03,
    72'h00_00455280_451216_00,
    72'h00_00451215_451243_03,
    72'h00_00451243_451215_03,
    72'h00_00451255_451203_00
  };

  rtc_alarm_top rtc_alarm_top_inst (
    .core_clk        (core_clk),
    .rst             (rst),
    .scl_in          (scl),
    .sda_in          (sda_line),
    .sda_out         (sda_out),
    .sda_oe          (sda_oe),
    .tick_1hz        (tick_1hz),
    .on_backup       (on_backup),
    .wave_or_irq_out (wave_or_irq_out),
    .wave_or_irq_oe  (wave_or_irq_oe)
  );

  i2c_host_model i2c_host_model_inst (
    .core_clk (core_clk),
    .sda_line (sda_line),
    .scl      (scl),
    .sda_low  (sda_low)
  );

  initial core_clk = 1'b0;
  always #4 core_clk = ~core_clk;

  // ****************************************
  // Compare and closing tasks
  // ****************************************
  task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic check_bit(input logic got, input logic exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic end_sim();
    $display("checks=%0d n_fail=%0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // ****************************************
  // Register access over the serial bus
  // ****************************************
  task automatic write_regs(input logic [7:0] ptr, input logic [7:0] d[$], input logic exp_ack);
    logic ack;
    i2c_host_model_inst.start_cond();
    i2c_host_model_inst.send_byte({DEVICE_ADDR, 1'b0}, ack);
    check_bit(ack, exp_ack);
    i2c_host_model_inst.send_byte(ptr, ack);
    foreach (d[i]) i2c_host_model_inst.send_byte(d[i], ack);
    i2c_host_model_inst.stop_cond();
  endtask

  task automatic read_regs(input logic [7:0] ptr, input logic [7:0] exp[$]);
    logic       ack;
    logic [7:0] got;
    i2c_host_model_inst.start_cond();
    i2c_host_model_inst.send_byte({DEVICE_ADDR, 1'b0}, ack);
    i2c_host_model_inst.send_byte(ptr, ack);
    i2c_host_model_inst.start_cond();
    i2c_host_model_inst.send_byte({DEVICE_ADDR, 1'b1}, ack);
    foreach (exp[i]) begin
      i2c_host_model_inst.recv_byte(i == exp.size() - 1, got);
      check_byte(got, exp[i]);
    end
    i2c_host_model_inst.stop_cond();
  endtask

  task automatic pulse_tick();
    tick_1hz <= 1'b1;
    repeat (8) @(posedge core_clk);
    tick_1hz <= 1'b0;
    repeat (8) @(posedge core_clk);
  endtask

  task automatic set_backup(input logic b);
    on_backup <= b;
    repeat (8) @(posedge core_clk);
  endtask

  // ****************************************
  // Tests
  // ****************************************
  initial begin
    rst = 1'b1;
    tick_1hz = 1'b0;
    on_backup = 1'b0;
    n_fail = 0;
    checks = 0;
    repeat (10) @(posedge core_clk);
    rst <= 1'b0;
    repeat (4) @(posedge core_clk);
    read_regs(8'h00, '{8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h01, 8'h00, 8'h00, 8'h00,
      8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h18, 8'h80, 8'h00});
    write_regs(8'h03, '{8'hFF}, 1'b1);
    read_regs(8'h03, '{8'h07});
    write_regs(8'h11, '{8'hAA}, 1'b1);
    read_regs(8'h11, '{8'h00});
    $display("test register map done");
    foreach (mask_rows[r]) begin
      write_regs(8'h00, '{mask_rows[r][71:64], 8'h45, 8'h12, 8'h03, 8'h15, 8'h01, 8'h00,
        mask_rows[r][63:56], mask_rows[r][55:48], mask_rows[r][47:40], mask_rows[r][39:32],
        mask_rows[r][31:24], mask_rows[r][23:16], mask_rows[r][15:8], 8'h07, 8'h00}, 1'b1);
      check_bit(wave_or_irq_oe, 1'b0);
      pulse_tick();
      check_bit(wave_or_irq_oe, |mask_rows[r][1:0]);
      read_regs(8'h0F, '{mask_rows[r][7:0]});
      $display("test mask row %0d done", r);
    end
    write_regs(8'h00, '{8'h00, 8'h45, 8'h12, 8'h03, 8'h15, 8'h01, 8'h00,
      8'h80, 8'h80, 8'h80, 8'h80, 8'h80, 8'h80, 8'h80, 8'h06, 8'h00}, 1'b1);
    pulse_tick();
    check_bit(wave_or_irq_oe, 1'b1);
    check_bit(irq_line, 1'b0);
    write_regs(8'h0F, '{8'h03}, 1'b1);
    read_regs(8'h0F, '{8'h03});
    check_bit(wave_or_irq_oe, 1'b1);
    write_regs(8'h0F, '{8'h01}, 1'b1);
    check_bit(wave_or_irq_oe, 1'b0);
    write_regs(8'h0E, '{8'h01}, 1'b1);
    check_bit(wave_or_irq_oe, 1'b0);
    write_regs(8'h0E, '{8'h05}, 1'b1);
    check_bit(wave_or_irq_oe, 1'b1);
    $display("test enables and clearing done");
    set_backup(1'b1);
    check_bit(wave_or_irq_oe, 1'b0);
    write_regs(8'h0E, '{8'h25}, 1'b0);
    set_backup(1'b0);
    check_bit(wave_or_irq_oe, 1'b1);
    read_regs(8'h0E, '{8'h05});
    write_regs(8'h0E, '{8'h25}, 1'b1);
    set_backup(1'b1);
    check_bit(wave_or_irq_oe, 1'b1);
    set_backup(1'b0);
    $display("test backup output done");
    end_sim();
  end

  // Run needs about 50000 cycles
  initial begin
    #(90000 * 8);
    n_fail++;
    $display("ERROR t=%0t watchdog expired", $time);
    end_sim();
  end

endmodule
